//--- testbench/test_ubl_uart.sv
// Self-checking bench for the UART channel.
`timescale 1ns/1ps
module test_ubl_uart;
  localparam int         BT = 208;
  localparam logic [7:0] LS = ubl_pkg::OFS_LSTAT;
  localparam logic [7:0] DT = ubl_pkg::OFS_DATA;
  logic sys_clk_i, reset_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, serial_out_o, baud_clock_out_o, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic line_status_event_o, rx_data_event_o, char_timeout_o;
  wire logic   serial_in_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, b8;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, v;
  logic [3:0]  s_axi_wstrb_i;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
  int          err_count = 0, check_count = 0;
  int          lv[4] = '{1, 4, 8, 14};
  ubl_uart i_ubl_uart (.*);
  ubl_serial_peer #(.BT(BT)) i_ubl_serial_peer (.sys_clk_i(sys_clk_i),
    .tx_line_i(serial_out_o), .rx_line_o(serial_in_i));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic da, dw, b;
    da = 1'b0;
    dw = 1'b0;
    @(posedge sys_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h00_0000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      da = da | s_axi_awready_o;
      dw = dw | s_axi_wready_o;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (da) s_axi_awvalid_i <= 1'b0;
      if (dw) s_axi_wvalid_i <= 1'b0;
    end while (b !== 1'b1);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic t, g;
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      t = s_axi_arready_o;
      g = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (t) s_axi_arvalid_i <= 1'b0;
    end while (g !== 1'b1);
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(n, e, v);
  endtask
  task automatic tick(input int e);
    int n;
    n = 0;
    do @(negedge sys_clk_i); while (baud_clock_out_o !== 1'b1);
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (baud_clock_out_o !== 1'b1);
    chk("tick", 32'(e), 32'(n));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    err_count++;
    tally_and_finish();
  end
  initial begin
    reset_i = 1'b1;
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = '0;
    s_axi_wstrb_i = 4'h1;
    repeat (20) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rc("lstat_rst", LS, 32'h0000_0060);
    rd(8'hFC);
    chk("rresp", 32'(ubl_pkg::RESP_ERR), 32'(r));
    wr(LS, 8'h00);
    chk("bresp", 32'(ubl_pkg::RESP_ERR), 32'(r));
    wr(ubl_pkg::OFS_DIV_HI, 8'h00);
    wr(ubl_pkg::OFS_DIV_LO, 8'h02);
    tick(26);
    wr(ubl_pkg::OFS_DIV_LO, 8'h01);
    tick(13);
    wr(ubl_pkg::OFS_IEN, 8'h04);
    i_ubl_serial_peer.send({3'b111, 8'hA5, 1'b0}, 10);
    rc("ready", LS, 32'h0000_0061);
    i_ubl_serial_peer.send({3'b111, 8'h5A, 1'b0}, 10);
    chk("ls_event", 32'h0000_0001, 32'(line_status_event_o));
    rc("overrun", LS, 32'h0000_0063);
    rc("ovr_clr", LS, 32'h0000_0061);
    rc("data", DT, 32'h0000_005A);
    rc("empty", LS, 32'h0000_0060);
    wr(DT, 8'h3C);
    rd(LS);
    chk("tx_all", 32'h0000_0000, 32'(v[6]));
    i_ubl_serial_peer.recv(b8);
    chk("tx_byte", 32'h0000_003C, {24'h00_0000, b8});
    repeat (2 * BT) @(posedge sys_clk_i);
    rc("tx_done", LS, 32'h0000_0060);
    wr(ubl_pkg::OFS_LCTRL, 8'h18);
    i_ubl_serial_peer.send({3'b111, 8'h03, 1'b0}, 11);
    rc("parity", LS, 32'h0000_0065);
    rc("par_data", DT, 32'h0000_0003);
    wr(ubl_pkg::OFS_LCTRL, 8'h00);
    wr(ubl_pkg::OFS_IDENT, 8'h01);
    wr(DT, 8'h55);
    repeat (30) @(posedge sys_clk_i);
    wr(DT, 8'h66);
    wr(ubl_pkg::OFS_IDENT, 8'h05);
    rc("tx_flush", LS, 32'h0000_0020);
    i_ubl_serial_peer.send({3'b110, 8'h11, 1'b0}, 10);
    repeat (10 * BT) @(posedge sys_clk_i);
    rc("framing", LS, 32'h0000_00E9);
    rc("fe_data", DT, 32'h0000_0011);
    rc("resync", DT, 32'h0000_00FF);
    rc("fifo_clr", LS, 32'h0000_0060);
    wr(ubl_pkg::OFS_IEN, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(ubl_pkg::OFS_IDENT, {k[1:0], 6'h03});
      for (int j = 0; j <= lv[k]; j++) begin
        chk("trigger", 32'(j >= lv[k]), 32'(rx_data_event_o));
        if (j < lv[k]) i_ubl_serial_peer.send({3'b111, 8'h40, 1'b0}, 10);
      end
    end
    repeat (41 * BT) @(posedge sys_clk_i);
    chk("timeout", 32'h0000_0001, 32'(char_timeout_o));
    rc("tout_pop", DT, 32'h0000_0040);
    chk("tout_clr", 32'h0000_0000, 32'(char_timeout_o));
    wr(ubl_pkg::OFS_IDENT, 8'h00);
    rc("mode_off", LS, 32'h0000_0060);
    i_ubl_serial_peer.send(12'h000, 12);
    rc("break", LS, 32'h0000_0079);
    rc("brk_data", DT, 32'h0000_0000);
    rc("brk_once", LS, 32'h0000_0060);
    tally_and_finish();
  end
endmodule

//--- testbench/ubl_serial_peer.sv
// Serial peer: drives the receive line and decodes the transmit line.
`timescale 1ns/1ps
module ubl_serial_peer #(parameter int BT = 208) (
  input  wire logic sys_clk_i,
  input  wire logic tx_line_i,
  output logic      rx_line_o
);
  initial rx_line_o = 1'b1;
  // Bits leave LSB first; the line returns to its high idle level after the frame.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_i);
      rx_line_o <= f[i];
      repeat (BT - 1) @(posedge sys_clk_i);
    end
    @(posedge sys_clk_i);
    rx_line_o <= 1'b1;
    repeat (BT) @(posedge sys_clk_i);
  endtask
  task automatic recv(output logic [7:0] d);
    wait (tx_line_i === 1'b0);
    repeat (BT / 2) @(negedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BT) @(negedge sys_clk_i);
      d[i] = tx_line_i;
    end
  endtask
endmodule

//--- testbench/ubl_uart_sva.sv
// Checker of bus handshakes, baud ticks and status events at the channel ports.
`timescale 1ns/1ps
module ubl_uart_sva (
  input wire logic        sys_clk_i, reset_i, baud_clock_out_o, serial_out_o,
  input wire logic        s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
  input wire logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic        s_axi_rvalid_o, s_axi_rready_i, line_status_event_o,
  input wire logic        rx_data_event_o, char_timeout_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic [31:0] s_axi_rdata_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // The gap counter starts full and saturates, so the first tick after reset is not judged.
  logic [4:0] gap_ff;
  wire        ar_go = s_axi_arvalid_i && s_axi_arready_o;
  wire        w_go  = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  always_ff @(posedge sys_clk_i)
    gap_ff <= reset_i ? 5'h1F : baud_clock_out_o ? 5'h00 : gap_ff + {4'h0, gap_ff != 5'h1F};
  property p_gap; baud_clock_out_o |-> gap_ff >= 5'h0C; endproperty
  a_gap: assert property (p_gap) else $error("baud tick too early");
  property p_lsc; (ar_go && s_axi_araddr_i == ubl_pkg::OFS_LSTAT) |=> !line_status_event_o;
  endproperty
  a_lsc: assert property (p_lsc) else $error("line event kept after status read");
  property p_tmo; (ar_go && s_axi_araddr_i == ubl_pkg::OFS_DATA) |=> !char_timeout_o; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout kept after data read");
  property p_bh; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bh: assert property (p_bh) else $error("write response dropped");
  property p_rh; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rh: assert property (p_rh) else $error("read data dropped");
  property p_ra; ar_go |=> s_axi_rvalid_o; endproperty
  a_ra: assert property (p_ra) else $error("read answer late");
  property p_wa; w_go |-> ##2 s_axi_bvalid_o; endproperty
  a_wa: assert property (p_wa) else $error("write answer late");
  property p_ref; s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o; endproperty
  a_ref: assert property (p_ref) else $error("write accepted while response pending");
  property p_hi; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_rst; disable iff (1'b0) reset_i |=> serial_out_o && !s_axi_bvalid_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_ls: cover property ($rose(line_status_event_o));
  c_rx: cover property ($rose(rx_data_event_o));
  c_be: cover property (s_axi_bvalid_o && s_axi_bresp_o == ubl_pkg::RESP_ERR);
endmodule
bind ubl_uart ubl_uart_sva i_ubl_uart_sva (.*);

//--- verilog/ubl_pkg.sv
// Package of register offsets, field positions, reset values and timing counts for the UART channel.
package ubl_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DATA      = 8'h00;
  localparam logic [7:0] OFS_IEN       = 8'h04;
  localparam logic [7:0] OFS_IDENT     = 8'h08;
  localparam logic [7:0] OFS_LCTRL     = 8'h0C;
  localparam logic [7:0] OFS_LSTAT     = 8'h14;
  localparam logic [7:0] OFS_DIV_LO    = 8'h20;
  localparam logic [7:0] OFS_DIV_HI    = 8'h24;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FC_ENABLE   = 0;
  localparam int FC_RX_FLUSH = 1;
  localparam int FC_TX_FLUSH = 2;
  localparam int FC_TRIG_LO  = 6;
  localparam int IE_RX_DATA  = 0;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_LINE     = 2;
  localparam int LC_PAR_EN   = 3;
  localparam int LC_PAR_EVEN = 4;
  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [15:0] DIV_RST   = 16'h0000;
  localparam logic [3:0]  IEN_RST   = 4'h0;
  localparam logic [1:0]  LC_RST    = 2'h0;
  localparam logic [1:0]  TRIG_RST  = 2'h0;
  localparam logic [4:0]  TRIG_L0   = 5'h01;
  localparam logic [4:0]  TRIG_L1   = 5'h04;
  localparam logic [4:0]  TRIG_L2   = 5'h08;
  localparam logic [4:0]  TRIG_L3   = 5'h0E;
  localparam logic [2:0]  ID_LINE   = 3'h3;
  localparam logic [2:0]  ID_RXDATA = 3'h2;
  localparam logic [2:0]  ID_TOUT   = 3'h6;
  localparam logic [2:0]  ID_TXEMP  = 3'h1;
  localparam logic [1:0]  RESP_OKAY = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam int PRESCALE    = 13;
  localparam int OVERSAMPLE  = 16;
  localparam int TOUT_CHARS  = 4;
  localparam logic [3:0] SMP_MID  = 4'h7;
  localparam logic [3:0] SMP_LAST = 4'hF;
  localparam logic [3:0] SMP_RESYNC = 4'h6;
  // ---------------------------------------------------------------
  // Receiver states
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA  = 6'b000100,
    RX_PAR   = 6'b001000,
    RX_STOP  = 6'b010000,
    RX_BRK   = 6'b100000
  } ubl_rx_state_t;
endpackage

//--- verilog/ubl_uart.sv
// One UART channel: baud generator, line status, FIFO control, AXI4-Lite registers.
`timescale 1ns/1ps
module ubl_uart #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output wire logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output wire logic        s_axi_wready_o,
  output wire logic [1:0]  s_axi_bresp_o,
  output wire logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output wire logic        s_axi_arready_o,
  output wire logic [31:0] s_axi_rdata_o,
  output wire logic [1:0]  s_axi_rresp_o,
  output wire logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Serial line
  input  wire logic        serial_in_i,
  output wire logic        serial_out_o,
  // Status outputs
  output wire logic        baud_clock_out_o,
  output wire logic        line_status_event_o,
  output wire logic        rx_data_event_o,
  output wire logic        char_timeout_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [4:0] CAP = 5'(DEPTH);
  function automatic int TOUT_CHARS_F(input int bits);
    return ubl_pkg::TOUT_CHARS * bits * ubl_pkg::OVERSAMPLE;
  endfunction
  localparam int TOUT_10 = TOUT_CHARS_F(10);
  localparam int TOUT_11 = TOUT_CHARS_F(11);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic        awv_ff, wv_ff, bv_ff, rv_ff, berr_ff, rerr_ff;
  logic [7:0]  awa_ff, wd_ff;
  logic        ws_ff;
  logic [7:0]  rd_ff;
  wire         wr_go = awv_ff & wv_ff & ~bv_ff;
  wire         rd_go = s_axi_arvalid_i & ~rv_ff;
  wire [7:0]   ra    = s_axi_araddr_i;
  wire         wr_en = wr_go & ws_ff;
  wire         w_data  = wr_en & (awa_ff == ubl_pkg::OFS_DATA);
  wire         w_ien   = wr_en & (awa_ff == ubl_pkg::OFS_IEN);
  wire         w_fc    = wr_en & (awa_ff == ubl_pkg::OFS_IDENT);
  wire         w_lc    = wr_en & (awa_ff == ubl_pkg::OFS_LCTRL);
  wire         w_dlo   = wr_en & (awa_ff == ubl_pkg::OFS_DIV_LO);
  wire         w_dhi   = wr_en & (awa_ff == ubl_pkg::OFS_DIV_HI);
  wire         wa_ok   = (awa_ff == ubl_pkg::OFS_DATA) | (awa_ff == ubl_pkg::OFS_IEN) |
                         (awa_ff == ubl_pkg::OFS_IDENT) | (awa_ff == ubl_pkg::OFS_LCTRL) |
                         (awa_ff == ubl_pkg::OFS_LSTAT) | (awa_ff == ubl_pkg::OFS_DIV_LO) |
                         (awa_ff == ubl_pkg::OFS_DIV_HI);
  wire         r_data  = rd_go & (ra == ubl_pkg::OFS_DATA);
  wire         r_lstat = rd_go & (ra == ubl_pkg::OFS_LSTAT);
  wire         ra_ok;
  wire [7:0]   rdat;

  assign s_axi_awready_o = ~awv_ff & ~bv_ff;
  assign s_axi_wready_o  = ~wv_ff & ~bv_ff;
  assign s_axi_bvalid_o  = bv_ff;
  assign s_axi_bresp_o   = berr_ff ? ubl_pkg::RESP_ERR : ubl_pkg::RESP_OKAY;
  assign s_axi_arready_o = ~rv_ff;
  assign s_axi_rvalid_o  = rv_ff;
  assign s_axi_rdata_o   = {24'h00_0000, rd_ff};
  assign s_axi_rresp_o   = rerr_ff ? ubl_pkg::RESP_ERR : ubl_pkg::RESP_OKAY;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic [15:0] div_ff;
  logic [3:0]  ien_ff;
  logic [1:0]  lc_ff, trig_ff;
  logic        fen_ff;
  wire         fc_on    = wd_ff[ubl_pkg::FC_ENABLE];
  wire         fc_chg   = w_fc & (fc_on != fen_ff);
  wire         rx_flush = fc_chg | (w_fc & fc_on & wd_ff[ubl_pkg::FC_RX_FLUSH]);
  wire         tx_flush = fc_chg | (w_fc & fc_on & wd_ff[ubl_pkg::FC_TX_FLUSH]);
  wire [15:0]  nxt_div  = w_dlo ? {div_ff[15:8], wd_ff} :
                          w_dhi ? {wd_ff, div_ff[7:0]} : div_ff;
  wire         par_en   = lc_ff[0];
  wire         par_even = lc_ff[1];
  wire [4:0]   cap      = fen_ff ? CAP : 5'h01;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      awv_ff <= 1'b0;
      wv_ff  <= 1'b0;
      bv_ff  <= 1'b0;
      berr_ff <= 1'b0;
      awa_ff <= 8'h00;
      wd_ff  <= 8'h00;
      ws_ff  <= 1'b0;
      rv_ff  <= 1'b0;
      rerr_ff <= 1'b0;
      rd_ff  <= 8'h00;
      div_ff <= ubl_pkg::DIV_RST;
      ien_ff <= ubl_pkg::IEN_RST;
      lc_ff  <= ubl_pkg::LC_RST;
      trig_ff <= ubl_pkg::TRIG_RST;
      fen_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        awv_ff <= 1'b1;
        awa_ff <= s_axi_awaddr_i;
      end else if (wr_go) begin
        awv_ff <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        wv_ff <= 1'b1;
        wd_ff <= s_axi_wdata_i[7:0];
        ws_ff <= s_axi_wstrb_i[0];
      end else if (wr_go) begin
        wv_ff <= 1'b0;
      end
      if (wr_go) begin
        bv_ff   <= 1'b1;
        berr_ff <= ~wa_ok | (awa_ff == ubl_pkg::OFS_LSTAT);
      end else if (s_axi_bready_i) begin
        bv_ff <= 1'b0;
      end
      if (rd_go) begin
        rv_ff   <= 1'b1;
        rd_ff   <= rdat;
        rerr_ff <= ~ra_ok;
      end else if (s_axi_rready_i) begin
        rv_ff <= 1'b0;
      end
      div_ff <= nxt_div;
      if (w_ien) ien_ff <= wd_ff[3:0];
      if (w_lc) lc_ff <= {wd_ff[ubl_pkg::LC_PAR_EVEN], wd_ff[ubl_pkg::LC_PAR_EN]};
      if (w_fc) fen_ff <= fc_on;
      if (w_fc & fc_on) trig_ff <= wd_ff[ubl_pkg::FC_TRIG_LO +: 2];
    end
  end

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------
  logic [3:0]  pre_ff;
  logic [15:0] bcnt_ff;
  logic        tick_ff;
  wire         pre_tick = (pre_ff == 4'(ubl_pkg::PRESCALE - 1));
  wire         b_term   = pre_tick & (bcnt_ff <= 16'h0001);
  wire         tick     = tick_ff;
  assign baud_clock_out_o = tick_ff;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pre_ff  <= 4'h0;
      bcnt_ff <= ubl_pkg::DIV_RST;
      tick_ff <= 1'b0;
    end else begin
      pre_ff  <= pre_tick ? 4'h0 : pre_ff + 4'h1;
      tick_ff <= b_term;
      if (w_dlo | w_dhi) bcnt_ff <= nxt_div;
      else if (b_term) bcnt_ff <= div_ff;
      else if (pre_tick) bcnt_ff <= bcnt_ff - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  logic rx_s1_ff, rx_s2_ff;
  ubl_pkg::ubl_rx_state_t st_ff;
  logic [3:0]  smp_ff;
  logic [2:0]  bit_ff;
  logic [7:0]  sh_ff;
  logic        par_ff, zero_ff, perr_ff, push_ff;
  logic [10:0] ent_ff;
  wire         rx = rx_s2_ff;
  wire         at_mid  = (smp_ff == ubl_pkg::SMP_MID);
  wire         at_last = (smp_ff == ubl_pkg::SMP_LAST);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      st_ff    <= ubl_pkg::RX_IDLE;
      smp_ff   <= 4'h0;
      bit_ff   <= 3'h0;
      sh_ff    <= 8'h00;
      par_ff   <= 1'b0;
      zero_ff  <= 1'b0;
      perr_ff  <= 1'b0;
      push_ff  <= 1'b0;
      ent_ff   <= 11'h000;
    end else begin
      rx_s1_ff <= serial_in_i;
      rx_s2_ff <= rx_s1_ff;
      push_ff  <= 1'b0;
      if (tick) begin
        smp_ff <= smp_ff + 4'h1;
        case (st_ff)
          ubl_pkg::RX_IDLE: begin
            smp_ff <= 4'h0;
            if (~rx) st_ff <= ubl_pkg::RX_START;
          end
          ubl_pkg::RX_START: begin
            if (at_mid) begin
              smp_ff  <= 4'h0;
              bit_ff  <= 3'h0;
              par_ff  <= 1'b0;
              zero_ff <= 1'b1;
              perr_ff <= 1'b0;
              st_ff   <= rx ? ubl_pkg::RX_IDLE : ubl_pkg::RX_DATA;
            end
          end
          ubl_pkg::RX_DATA: begin
            if (at_last) begin
              sh_ff   <= {rx, sh_ff[7:1]};
              par_ff  <= par_ff ^ rx;
              zero_ff <= zero_ff & ~rx;
              bit_ff  <= bit_ff + 3'h1;
              if (bit_ff == 3'h7) st_ff <= par_en ? ubl_pkg::RX_PAR : ubl_pkg::RX_STOP;
            end
          end
          ubl_pkg::RX_PAR: begin
            if (at_last) begin
              perr_ff <= par_ff ^ rx ^ ~par_even;
              zero_ff <= zero_ff & ~rx;
              st_ff   <= ubl_pkg::RX_STOP;
            end
          end
          ubl_pkg::RX_STOP: begin
            if (at_last) begin
              push_ff <= 1'b1;
              ent_ff  <= {zero_ff & ~rx, ~rx, perr_ff, sh_ff};
              if (zero_ff & ~rx) begin
                st_ff  <= ubl_pkg::RX_BRK;
                smp_ff <= 4'h0;
              end else if (~rx) begin
                st_ff  <= ubl_pkg::RX_START;
                smp_ff <= ubl_pkg::SMP_RESYNC;
              end else begin
                st_ff  <= ubl_pkg::RX_IDLE;
              end
            end
          end
          ubl_pkg::RX_BRK: begin
            if (~rx) smp_ff <= 4'h0;
            else if (at_mid) st_ff <= ubl_pkg::RX_IDLE;
          end
          default: st_ff <= ubl_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive FIFO and line status
  // ---------------------------------------------------------------
  logic [10:0]   rxm [DEPTH];
  logic [AW-1:0] rwp_ff, rrp_ff;
  logic [4:0]    rcnt_ff;
  logic          oe_ff, pf_ff, fr_ff, bk_ff, hnew_ff;
  logic [9:0]    to_ff;
  logic [DEPTH-1:0] err_v;
  wire           pop    = r_data & (rcnt_ff != 5'h00);
  wire           full   = (rcnt_ff >= cap) & ~pop;
  wire           wr_new = push_ff & ~full;
  wire           ovw    = push_ff & full & ~fen_ff;
  wire           ovr    = push_ff & full;
  wire [10:0]    head   = rxm[rrp_ff];
  wire           rdy    = (rcnt_ff != 5'h00);
  wire           fifo_err = fen_ff & (|err_v);

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_err
      wire [AW-1:0] rel = AW'(gi) - rrp_ff;
      assign err_v[gi] = ({1'b0, rel} < rcnt_ff) & (|rxm[gi][10:8]);
    end
  endgenerate

  wire [9:0] to_lim = par_en ? 10'(TOUT_11) : 10'(TOUT_10);
  wire [4:0] trig_n = (trig_ff == 2'h0) ? ubl_pkg::TRIG_L0 :
                      (trig_ff == 2'h1) ? ubl_pkg::TRIG_L1 :
                      (trig_ff == 2'h2) ? ubl_pkg::TRIG_L2 : ubl_pkg::TRIG_L3;
  wire       tout   = fen_ff & rdy & (to_ff >= to_lim);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rwp_ff  <= '0;
      rrp_ff  <= '0;
      rcnt_ff <= 5'h00;
      oe_ff   <= 1'b0;
      pf_ff   <= 1'b0;
      fr_ff   <= 1'b0;
      bk_ff   <= 1'b0;
      hnew_ff <= 1'b0;
      to_ff   <= 10'h000;
    end else begin
      if (wr_new) rxm[rwp_ff] <= ent_ff;
      else if (ovw) rxm[rrp_ff] <= ent_ff;
      hnew_ff <= (wr_new & (rcnt_ff == 5'h00)) | (pop & (rcnt_ff > 5'h01)) | ovw;
      if (rx_flush) begin
        rwp_ff  <= '0;
        rrp_ff  <= '0;
        rcnt_ff <= 5'h00;
      end else begin
        if (wr_new) rwp_ff <= rwp_ff + AW'(1);
        if (pop) rrp_ff <= rrp_ff + AW'(1);
        rcnt_ff <= rcnt_ff + {4'h0, wr_new} - {4'h0, pop};
      end
      // Hardware set wins over the read-clear of the same cycle.
      if (ovr) oe_ff <= 1'b1;
      else if (r_lstat) oe_ff <= 1'b0;
      if (hnew_ff & head[8]) pf_ff <= 1'b1;
      else if (r_lstat) pf_ff <= 1'b0;
      if (hnew_ff & head[9]) fr_ff <= 1'b1;
      else if (r_lstat) fr_ff <= 1'b0;
      if (hnew_ff & head[10]) bk_ff <= 1'b1;
      else if (r_lstat) bk_ff <= 1'b0;
      if (wr_new | pop | ~rdy | ~fen_ff) to_ff <= 10'h000;
      else if (tick & ~tout) to_ff <= to_ff + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  logic [7:0]    txm [DEPTH];
  logic [AW-1:0] twp_ff, trp_ff;
  logic [4:0]    tcnt_ff;
  logic          busy_ff, txd_ff;
  logic [10:0]   tsh_ff;
  logic [3:0]    tsmp_ff, tbit_ff;
  wire           t_push = w_data & (tcnt_ff < cap);
  wire           t_load = tick & ~busy_ff & (tcnt_ff != 5'h00);
  wire [7:0]     t_head = txm[trp_ff];
  wire           t_par  = par_even ? (^t_head) : ~(^t_head);
  wire           hld_emp = (tcnt_ff == 5'h00);
  wire           all_emp = hld_emp & ~busy_ff;
  assign serial_out_o = txd_ff;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      twp_ff  <= '0;
      trp_ff  <= '0;
      tcnt_ff <= 5'h00;
      busy_ff <= 1'b0;
      txd_ff  <= 1'b1;
      tsh_ff  <= 11'h7FF;
      tsmp_ff <= 4'h0;
      tbit_ff <= 4'h0;
    end else begin
      if (t_push) txm[twp_ff] <= wd_ff;
      if (tx_flush) begin
        twp_ff  <= '0;
        trp_ff  <= '0;
        tcnt_ff <= 5'h00;
      end else begin
        if (t_push) twp_ff <= twp_ff + AW'(1);
        if (t_load) trp_ff <= trp_ff + AW'(1);
        tcnt_ff <= tcnt_ff + {4'h0, t_push} - {4'h0, t_load};
      end
      if (t_load & ~tx_flush) begin
        busy_ff <= 1'b1;
        tsh_ff  <= {1'b1, par_en ? t_par : 1'b1, t_head, 1'b0};
        tsmp_ff <= 4'h0;
        tbit_ff <= par_en ? 4'hB : 4'hA;
      end else if (tick & busy_ff) begin
        txd_ff  <= tsh_ff[0];
        tsmp_ff <= tsmp_ff + 4'h1;
        if (tsmp_ff == ubl_pkg::SMP_LAST) begin
          tsh_ff  <= {1'b1, tsh_ff[10:1]};
          tbit_ff <= tbit_ff - 4'h1;
          if (tbit_ff == 4'h1) busy_ff <= 1'b0;
        end
      end else if (~busy_ff) begin
        txd_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status views and read mux
  // ---------------------------------------------------------------
  wire [7:0] lstat   = {fifo_err, all_emp, hld_emp, bk_ff, fr_ff, pf_ff, oe_ff, rdy};
  wire       ls_ev   = ien_ff[ubl_pkg::IE_LINE] & (oe_ff | pf_ff | fr_ff | bk_ff);
  wire       rd_lvl  = fen_ff ? (rcnt_ff >= trig_n) : rdy;
  wire       rd_ev   = ien_ff[ubl_pkg::IE_RX_DATA] & (rd_lvl | tout);
  wire       te_ev   = ien_ff[ubl_pkg::IE_TX_EMPTY] & hld_emp;
  wire [2:0] id      = ls_ev ? ubl_pkg::ID_LINE :
                       (ien_ff[ubl_pkg::IE_RX_DATA] & rd_lvl) ? ubl_pkg::ID_RXDATA :
                       rd_ev ? ubl_pkg::ID_TOUT :
                       te_ev ? ubl_pkg::ID_TXEMP : 3'h0;
  wire [7:0] ident   = {fen_ff, fen_ff, 2'h0, id, ~(ls_ev | rd_ev | te_ev)};
  assign ra_ok       = (ra == ubl_pkg::OFS_DATA) | (ra == ubl_pkg::OFS_IEN) |
                       (ra == ubl_pkg::OFS_IDENT) | (ra == ubl_pkg::OFS_LCTRL) |
                       (ra == ubl_pkg::OFS_LSTAT) | (ra == ubl_pkg::OFS_DIV_LO) |
                       (ra == ubl_pkg::OFS_DIV_HI);
  // Reading the data register of an empty receiver returns the stale head.
  assign rdat        = (ra == ubl_pkg::OFS_DATA)   ? head[7:0] :
                       (ra == ubl_pkg::OFS_IEN)    ? {4'h0, ien_ff} :
                       (ra == ubl_pkg::OFS_IDENT)  ? ident :
                       (ra == ubl_pkg::OFS_LCTRL)  ? {3'h0, par_even, par_en, 3'h0} :
                       (ra == ubl_pkg::OFS_LSTAT)  ? lstat :
                       (ra == ubl_pkg::OFS_DIV_LO) ? div_ff[7:0] :
                       (ra == ubl_pkg::OFS_DIV_HI) ? div_ff[15:8] : 8'h00;

  assign line_status_event_o = ls_ev;
  assign rx_data_event_o     = rd_ev;
  assign char_timeout_o      = tout;
endmodule
